// ===== design/dcos_pkg.sv
package dcos_pkg;

  // Register indices; each byte address is four times the index
  localparam logic [9:0] IDX_CHANNEL_COUNT   = 10'h200;
  localparam logic [9:0] IDX_CHIP_DECIMATION = 10'h201;
  localparam logic [9:0] IDX_STATUS          = 10'h202;
  localparam logic [9:0] IDX_CH0_MODE        = 10'h310;
  localparam logic [9:0] IDX_CH0_ROUTING     = 10'h311;
  localparam logic [9:0] IDX_CH0_TUNING_A    = 10'h314;
  localparam logic [9:0] IDX_CH0_TUNING_B    = 10'h315;
  localparam logic [9:0] IDX_CH0_PHASE_A     = 10'h320;
  localparam logic [9:0] IDX_CH0_PHASE_B     = 10'h321;
  localparam logic [9:0] IDX_CH1_MODE        = 10'h330;
  localparam logic [9:0] IDX_CH1_ROUTING     = 10'h331;
  localparam logic [9:0] IDX_CH1_TUNING_A    = 10'h334;
  localparam logic [9:0] IDX_CH1_TUNING_B    = 10'h335;
  localparam logic [9:0] IDX_CH1_PHASE_A     = 10'h340;
  localparam logic [9:0] IDX_CH1_PHASE_B     = 10'h341;

  // Values after reset
  localparam logic [7:0] RST_CHANNEL_COUNT   = 8'h01;
  localparam logic [7:0] RST_CHIP_DECIMATION = 8'h01;
  localparam logic [7:0] RST_MODE            = 8'h83;
  localparam logic [7:0] RST_ROUTING         = 8'h04;
  localparam logic [7:0] RST_OSC_BYTE        = 8'h00;

  // Field positions
  localparam int CNT_TWO_BIT     = 1;  // Second channel enabled
  localparam int CNT_QIGNORE_BIT = 5;  // Quadrature output dropped
  localparam int MODE_CPLX_BIT   = 7;  // Complex mixing upstream
  localparam int MODE_GAIN_BIT   = 6;  // 6 dB gain
  localparam int MODE_REAL_BIT   = 3;  // Real output, complex-to-real on
  localparam int MODE_FILT_LSB   = 0;  // Filter cascade, two bits
  localparam logic [1:0] FILT_FINAL_ONLY = 2'h3;
  localparam int ROUTE_I_BIT     = 0;  // 0: converter A, 1: converter B
  localparam int ROUTE_Q_BIT     = 2;  // 0: converter A, 1: converter B

  // Bus answers
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Final half-band filter: 55 taps, odd taps mirrored, even taps zero
  localparam int TAPS       = 55;
  localparam int CENTRE_IDX = 27;
  localparam int NPAIRS     = 14;
  localparam int FRAC_BITS  = 20;
  localparam logic signed [20:0] HB_CENTRE = 21'sh080000;
  localparam logic signed [20:0] HB_COEF [NPAIRS] = '{
    21'sh1fffe8, 21'sh000066, 21'sh1ffed2, 21'sh0002da,
    21'sh1ff9f8, 21'sh000b94, 21'sh1feb5c, 21'sh0022c7,
    21'sh1fc7d1, 21'sh005870, 21'sh1f756c, 21'sh00e07c,
    21'sh1e641e, 21'sh051010
  };

endpackage

// ===== design/dcos_top.sv
// The AXI4-Lite interface to the registers was chosen for this implementation.
`timescale 1ns/1ps
// Summary of operation
// - Final stage: 55-tap half-band, decimate by two
// - Final half-band always in every channel path
// - Per-channel gain select, 0 dB or 6 dB
// - 6 dB stays selectable with complex input
// - Complex-to-real keeps filter, skips downsampling
// - Per-channel complex-to-real via quarter-rate mixer
// - After mixing, drop Q, output real only
// - Count 0x01: one channel, I and Q
// - Count 0x02: two channels, I and Q
// - Count 0x22: two channels, Q ignored
// - Chip decimation 0x01 by two, 0x02 four
// - Mode 0x83: complex, 0 dB, final only
// - Mode 0x80: last two half-bands cascaded
// - Mode 0x89: real output, last three half-bands
// - Routing 0x04: I from A, Q from B
// - Second channel settings at 0x330, 0x331
// - Oscillator words held at their own offsets
// - Coefficients 21-bit, centre 524288, even zero
// - Third stage only when cascade asks, else bypassed

module dcos_top #(
  parameter int DW    = 16,  // Sample width
  parameter int ACC_W = 48   // Accumulator width
) (
  // Clock and reset
  input  wire  logic                  aclk,
  input  wire  logic                  aresetn,
  // AXI4-Lite write address
  input  wire  logic [11:0]           s_axi_awaddr,
  input  wire  logic                  s_axi_awvalid,
  output logic                        s_axi_awready,
  // AXI4-Lite write data
  input  wire  logic [31:0]           s_axi_wdata,
  input  wire  logic [3:0]            s_axi_wstrb,
  input  wire  logic                  s_axi_wvalid,
  output logic                        s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]                  s_axi_bresp,
  output logic                        s_axi_bvalid,
  input  wire  logic                  s_axi_bready,
  // AXI4-Lite read address
  input  wire  logic [11:0]           s_axi_araddr,
  input  wire  logic                  s_axi_arvalid,
  output logic                        s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0]                 s_axi_rdata,
  output logic [1:0]                  s_axi_rresp,
  output logic                        s_axi_rvalid,
  input  wire  logic                  s_axi_rready,
  // Samples from the earlier half-band stages
  input  wire  logic                  in_valid,
  input  wire  logic signed [DW-1:0]  in_a_data,
  input  wire  logic signed [DW-1:0]  in_b_data,
  // Samples to the link framer
  output logic [1:0]                  out_valid,
  output logic [1:0]                  out_q_valid,
  output logic [1:0][DW-1:0]          out_i_data,
  output logic [1:0][DW-1:0]          out_q_data,
  // Settings for the oscillator and earlier stages
  output logic [1:0][15:0]            oscillator_tuning_word,
  output logic [1:0][15:0]            oscillator_phase_offset_word,
  output logic [1:0]                  third_halfband_enable,
  output logic [7:0]                  chip_decimation_select
);

  localparam int NCH = 2;
  // Saturation limits at accumulator width
  localparam logic signed [ACC_W-1:0] SAT_MAX =
    {{(ACC_W-DW+1){1'b0}}, {(DW-1){1'b1}}};
  localparam logic signed [ACC_W-1:0] SAT_MIN =
    {{(ACC_W-DW+1){1'b1}}, {(DW-1){1'b0}}};

  // Software-visible registers
  logic [7:0]           channel_count_select;  // Channel count control
  logic [1:0][7:0]      mode_control;          // Per-channel mode
  logic [1:0][7:0]      input_routing;         // Per-channel input select

  // Bus slave state
  logic                 aw_got;       // Write address held
  logic                 w_got;        // Write data held
  logic [9:0]           wr_index;     // Held write index
  logic [31:0]          wr_data;      // Held write data
  logic                 wr_lane0;     // Held strobe for byte lane 0
  // Per-channel state that the status word shows
  logic [1:0][7:0]      out_count;    // Outputs delivered, wraps
  // Scale the accumulator to the output word, optional 6 dB, saturate
  function automatic logic signed [DW-1:0] scale_sat(
    input logic signed [ACC_W-1:0] v,
    input logic                    gain6
  );
    logic signed [ACC_W-1:0] s;
    s = gain6 ? (v >>> (dcos_pkg::FRAC_BITS - 1)) :
                (v >>> dcos_pkg::FRAC_BITS);
    if (s > SAT_MAX) begin
      scale_sat = SAT_MAX[DW-1:0];
    end else if (s < SAT_MIN) begin
      scale_sat = SAT_MIN[DW-1:0];
    end else begin
      scale_sat = s[DW-1:0];
    end
  endfunction

  // Channel enables decoded from the count control
  wire ch0_enable = |channel_count_select;
  wire ch1_enable =
    channel_count_select[dcos_pkg::CNT_TWO_BIT];
  wire q_ignore   =
    channel_count_select[dcos_pkg::CNT_QIGNORE_BIT];
  wire [1:0] ch_enable = {ch1_enable, ch0_enable};
  // Bus handshakes
  wire aw_fire  = s_axi_awvalid & s_axi_awready;
  wire w_fire   = s_axi_wvalid & s_axi_wready;
  wire ar_fire  = s_axi_arvalid & s_axi_arready;
  wire do_write = aw_got & w_got & ~s_axi_bvalid;
  wire next_aw_got = (aw_got | aw_fire) & ~do_write;
  wire next_w_got  = (w_got | w_fire) & ~do_write;
  wire next_bvalid = do_write | (s_axi_bvalid & ~s_axi_bready);
  wire next_rvalid = ar_fire | (s_axi_rvalid & ~s_axi_rready);
  // Write decode on the held index
  wire wr_en        = do_write & wr_lane0;
  wire hit_count    = wr_index == dcos_pkg::IDX_CHANNEL_COUNT;
  wire hit_decim    = wr_index == dcos_pkg::IDX_CHIP_DECIMATION;
  wire hit_status   = wr_index == dcos_pkg::IDX_STATUS;
  wire hit_mode0    = wr_index == dcos_pkg::IDX_CH0_MODE;
  wire hit_route0   = wr_index == dcos_pkg::IDX_CH0_ROUTING;
  wire hit_tune0a   = wr_index == dcos_pkg::IDX_CH0_TUNING_A;
  wire hit_tune0b   = wr_index == dcos_pkg::IDX_CH0_TUNING_B;
  wire hit_phase0a  = wr_index == dcos_pkg::IDX_CH0_PHASE_A;
  wire hit_phase0b  = wr_index == dcos_pkg::IDX_CH0_PHASE_B;
  wire hit_mode1    = wr_index == dcos_pkg::IDX_CH1_MODE;
  wire hit_route1   = wr_index == dcos_pkg::IDX_CH1_ROUTING;
  wire hit_tune1a   = wr_index == dcos_pkg::IDX_CH1_TUNING_A;
  wire hit_tune1b   = wr_index == dcos_pkg::IDX_CH1_TUNING_B;
  wire hit_phase1a  = wr_index == dcos_pkg::IDX_CH1_PHASE_A;
  wire hit_phase1b  = wr_index == dcos_pkg::IDX_CH1_PHASE_B;
  // Status is read-only: a write there is refused like a hole
  wire wr_mapped = hit_count | hit_decim | hit_mode0 | hit_route0 |
                   hit_tune0a | hit_tune0b | hit_phase0a | hit_phase0b |
                   hit_mode1 | hit_route1 | hit_tune1a | hit_tune1b |
                   hit_phase1a | hit_phase1b;

  // Read selection, narrow registers in the low byte
  wire [9:0] rd_index = s_axi_araddr[11:2];
  wire [31:0] status_word = {8'h00, out_count[1], out_count[0], 3'h0,
                             mode_control[1][dcos_pkg::MODE_REAL_BIT],
                             mode_control[0][dcos_pkg::MODE_REAL_BIT],
                             q_ignore, ch1_enable, ch0_enable};
  wire [7:0] rd_byte =
    (rd_index == dcos_pkg::IDX_CHANNEL_COUNT)   ? channel_count_select :
    (rd_index == dcos_pkg::IDX_CHIP_DECIMATION) ? chip_decimation_select :
    (rd_index == dcos_pkg::IDX_CH0_MODE)        ? mode_control[0] :
    (rd_index == dcos_pkg::IDX_CH0_ROUTING)     ? input_routing[0] :
    (rd_index == dcos_pkg::IDX_CH0_TUNING_A)    ?
      oscillator_tuning_word[0][7:0] :
    (rd_index == dcos_pkg::IDX_CH0_TUNING_B)    ?
      oscillator_tuning_word[0][15:8] :
    (rd_index == dcos_pkg::IDX_CH0_PHASE_A)     ?
      oscillator_phase_offset_word[0][7:0] :
    (rd_index == dcos_pkg::IDX_CH0_PHASE_B)     ?
      oscillator_phase_offset_word[0][15:8] :
    (rd_index == dcos_pkg::IDX_CH1_MODE)        ? mode_control[1] :
    (rd_index == dcos_pkg::IDX_CH1_ROUTING)     ? input_routing[1] :
    (rd_index == dcos_pkg::IDX_CH1_TUNING_A)    ?
      oscillator_tuning_word[1][7:0] :
    (rd_index == dcos_pkg::IDX_CH1_TUNING_B)    ?
      oscillator_tuning_word[1][15:8] :
    (rd_index == dcos_pkg::IDX_CH1_PHASE_A)     ?
      oscillator_phase_offset_word[1][7:0] :
    (rd_index == dcos_pkg::IDX_CH1_PHASE_B)     ?
      oscillator_phase_offset_word[1][15:8] : 8'h00;
  wire rd_is_status = rd_index == dcos_pkg::IDX_STATUS;
  wire rd_mapped = rd_is_status |
    (rd_index == dcos_pkg::IDX_CHANNEL_COUNT) |
    (rd_index == dcos_pkg::IDX_CHIP_DECIMATION) |
    (rd_index == dcos_pkg::IDX_CH0_MODE) |
    (rd_index == dcos_pkg::IDX_CH0_ROUTING) |
    (rd_index == dcos_pkg::IDX_CH0_TUNING_A) |
    (rd_index == dcos_pkg::IDX_CH0_TUNING_B) |
    (rd_index == dcos_pkg::IDX_CH0_PHASE_A) |
    (rd_index == dcos_pkg::IDX_CH0_PHASE_B) |
    (rd_index == dcos_pkg::IDX_CH1_MODE) |
    (rd_index == dcos_pkg::IDX_CH1_ROUTING) |
    (rd_index == dcos_pkg::IDX_CH1_TUNING_A) |
    (rd_index == dcos_pkg::IDX_CH1_TUNING_B) |
    (rd_index == dcos_pkg::IDX_CH1_PHASE_A) |
    (rd_index == dcos_pkg::IDX_CH1_PHASE_B);
  wire [31:0] rd_value = rd_is_status ? status_word : {24'h0, rd_byte};

  // Write channel: address and data taken in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got        <= 1'b0;
      w_got         <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= dcos_pkg::RESP_OKAY;
      wr_index      <= 10'h000;
      wr_data       <= 32'h0;
      wr_lane0      <= 1'b0;
    end else begin
      aw_got        <= next_aw_got;
      w_got         <= next_w_got;
      // Ready drops while a word is held so a second cannot overwrite it
      s_axi_awready <= ~next_aw_got & ~next_bvalid;
      s_axi_wready  <= ~next_w_got & ~next_bvalid;
      s_axi_bvalid  <= next_bvalid;
      if (aw_fire) begin
        wr_index <= s_axi_awaddr[11:2];
      end
      if (w_fire) begin
        wr_data  <= s_axi_wdata;
        wr_lane0 <= s_axi_wstrb[0];
      end
      // Holes and the status word answer with a slave error
      if (do_write) begin
        s_axi_bresp <= wr_mapped ? dcos_pkg::RESP_OKAY :
                                   dcos_pkg::RESP_SLVERR;
      end
    end
  end

  // Read channel: one cycle from address to data
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0;
      s_axi_rresp   <= dcos_pkg::RESP_OKAY;
    end else begin
      s_axi_arready <= ~next_rvalid;
      s_axi_rvalid  <= next_rvalid;
      if (ar_fire) begin
        s_axi_rdata <= rd_value;
        s_axi_rresp <= rd_mapped ? dcos_pkg::RESP_OKAY :
                                   dcos_pkg::RESP_SLVERR;
      end
    end
  end

  // Global settings
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      channel_count_select   <= dcos_pkg::RST_CHANNEL_COUNT;
      chip_decimation_select <= dcos_pkg::RST_CHIP_DECIMATION;
    end else begin
      if (wr_en && hit_count) begin
        channel_count_select <= wr_data[7:0];
      end
      if (wr_en && hit_decim) begin
        chip_decimation_select <= wr_data[7:0];
      end
    end
  end

  // Per-channel settings, one register set per channel
  wire [1:0] w_mode   = {hit_mode1, hit_mode0};
  wire [1:0] w_route  = {hit_route1, hit_route0};
  wire [1:0] w_tune_a = {hit_tune1a, hit_tune0a};
  wire [1:0] w_tune_b = {hit_tune1b, hit_tune0b};
  wire [1:0] w_ph_a   = {hit_phase1a, hit_phase0a};
  wire [1:0] w_ph_b   = {hit_phase1b, hit_phase0b};

  for (genvar c = 0; c < NCH; c++) begin : g_ch
    logic signed [DW-1:0]    line_i [dcos_pkg::TAPS];  // I delay line
    logic signed [DW-1:0]    line_q [dcos_pkg::TAPS];  // Q delay line
    logic                    dec_phase;  // Odd/even input sample
    logic [1:0]              mix_phase;  // Quarter-rate mixer step
    logic                    fire;       // Filter result due this cycle
    logic signed [ACC_W-1:0] acc_i;      // I filter sum
    logic signed [ACC_W-1:0] acc_q;      // Q filter sum
    logic signed [ACC_W-1:0] mix_re;     // Real part after upconversion

    wire gain6 = mode_control[c][dcos_pkg::MODE_GAIN_BIT];
    wire c2r   = mode_control[c][dcos_pkg::MODE_REAL_BIT];
    wire signed [DW-1:0] sample_i =
      input_routing[c][dcos_pkg::ROUTE_I_BIT] ? in_b_data
                                              : in_a_data;
    wire signed [DW-1:0] sample_q =
      input_routing[c][dcos_pkg::ROUTE_Q_BIT] ? in_b_data
                                              : in_a_data;
    wire [1:0] filt = mode_control[c][dcos_pkg::MODE_FILT_LSB +: 2];

    // Settings; the second set lives at its own offsets
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        mode_control[c]  <= dcos_pkg::RST_MODE;
        input_routing[c] <= dcos_pkg::RST_ROUTING;
        oscillator_tuning_word[c] <=
          {dcos_pkg::RST_OSC_BYTE, dcos_pkg::RST_OSC_BYTE};
        oscillator_phase_offset_word[c] <=
          {dcos_pkg::RST_OSC_BYTE, dcos_pkg::RST_OSC_BYTE};
        third_halfband_enable[c] <= 1'b0;
      end else begin
        if (wr_en && w_mode[c]) begin
          mode_control[c] <= wr_data[7:0];
        end
        if (wr_en && w_route[c]) begin
          input_routing[c] <= wr_data[7:0];
        end
        if (wr_en && w_tune_a[c]) begin
          oscillator_tuning_word[c][7:0] <= wr_data[7:0];
        end
        if (wr_en && w_tune_b[c]) begin
          oscillator_tuning_word[c][15:8] <= wr_data[7:0];
        end
        if (wr_en && w_ph_a[c]) begin
          oscillator_phase_offset_word[c][7:0] <= wr_data[7:0];
        end
        if (wr_en && w_ph_b[c]) begin
          oscillator_phase_offset_word[c][15:8] <= wr_data[7:0];
        end
        // Earlier stage joins only when more than the final is chosen
        third_halfband_enable[c] <=
          filt != dcos_pkg::FILT_FINAL_ONLY;
      end
    end

    // Delay lines shift on every input; the filter is never bypassed
    always_ff @(posedge aclk) begin
      if (in_valid) begin
        line_i[0] <= sample_i;
        line_q[0] <= sample_q;
        for (int k = 1; k < dcos_pkg::TAPS; k++) begin
          line_i[k] <= line_i[k-1];
          line_q[k] <= line_q[k-1];
        end
      end
    end

    // Folded half-band sum: mirrored odd taps plus centre
    always_comb begin
      acc_i = ACC_W'(dcos_pkg::HB_CENTRE) *
              ACC_W'(line_i[dcos_pkg::CENTRE_IDX]);
      acc_q = ACC_W'(dcos_pkg::HB_CENTRE) *
              ACC_W'(line_q[dcos_pkg::CENTRE_IDX]);
      for (int k = 0; k < dcos_pkg::NPAIRS; k++) begin
        acc_i = acc_i + ACC_W'(dcos_pkg::HB_COEF[k]) *
                (ACC_W'(line_i[2*k]) +
                 ACC_W'(line_i[dcos_pkg::TAPS-1-2*k]));
        acc_q = acc_q + ACC_W'(dcos_pkg::HB_COEF[k]) *
                (ACC_W'(line_q[2*k]) +
                 ACC_W'(line_q[dcos_pkg::TAPS-1-2*k]));
      end
    end

    // Quarter-rate upconversion keeps only the real part
    always_comb begin
      case (mix_phase)
        2'h0:    mix_re = acc_i;
        2'h1:    mix_re = -acc_q;
        2'h2:    mix_re = -acc_i;
        2'h3:    mix_re = acc_q;
        default: mix_re = acc_i;
      endcase
    end

    // Saturation after mixing so a negated full-scale cannot wrap
    wire signed [DW-1:0] next_i =
      scale_sat(c2r ? mix_re : acc_i, gain6);
    wire signed [DW-1:0] next_q = scale_sat(acc_q, gain6);

    // Decimation control and outputs
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        dec_phase        <= 1'b0;
        mix_phase        <= 2'h0;
        fire             <= 1'b0;
        out_valid[c]     <= 1'b0;
        out_q_valid[c]   <= 1'b0;
        out_i_data[c]    <= '0;
        out_q_data[c]    <= '0;
        out_count[c]     <= 8'h00;
      end else begin
        if (in_valid) begin
          dec_phase <= ~dec_phase;
        end
        // Every second input, or every input with conversion on
        fire <= in_valid & ch_enable[c] & (c2r | dec_phase);
        out_valid[c]   <= fire;
        out_q_valid[c] <= fire & ~c2r & ~q_ignore;
        if (!c2r) begin
          mix_phase <= 2'h0;
        end else if (fire) begin
          mix_phase <= mix_phase + 2'h1;
        end
        if (fire) begin
          out_i_data[c] <= next_i;
          out_q_data[c] <= (c2r | q_ignore) ? '0 : next_q;
          out_count[c]  <= out_count[c] + 8'h01;
        end
      end
    end
  end
endmodule

// ===== tb/dcos_monitor.sv
`timescale 1ns/1ps
// Port-level checker for the bus handshakes and the sample strobes
module dcos_monitor #(
  parameter int DW = 16  // Sample width, as in the block
) (
  // Clock and reset
  input wire logic                 aclk,
  input wire logic                 aresetn,
  // Register bus handshakes
  input wire logic                 s_axi_awready,
  input wire logic                 s_axi_wready,
  input wire logic                 s_axi_bvalid,
  input wire logic                 s_axi_bready,
  input wire logic                 s_axi_arvalid,
  input wire logic                 s_axi_arready,
  input wire logic                 s_axi_rvalid,
  input wire logic                 s_axi_rready,
  input wire logic [31:0]          s_axi_rdata,
  // Sample stream
  input wire logic                 in_valid,
  input wire logic [1:0]           out_valid,
  input wire logic [1:0]           out_q_valid,
  input wire logic [1:0][DW-1:0]   out_q_data
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Q word must read zero whenever its strobe stays low beside I
  wire q_leak = (out_valid[0] && !out_q_valid[0] && out_q_data[0] != '0) ||
                (out_valid[1] && !out_q_valid[1] && out_q_data[1] != '0);
  q_beside_i_a: assert property (
    (out_q_valid & ~out_valid) == 2'h0) else $error("Q strobe alone");
  q_zero_a: assert property (!q_leak) else $error("Q data leaked");
  strobe_cause_a: assert property (
    out_valid != 2'h0 |-> $past(in_valid, 2)) else $error("Strobe uncaused");
  rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=>
    s_axi_rvalid) else $error("Read answer late");
  rd_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("Read data moved");
  ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("Read taken while busy");
  w_block_a: assert property (s_axi_bvalid |-> !s_axi_awready &&
    !s_axi_wready) else $error("Write taken while busy");
  w_return_a: assert property (s_axi_bvalid && s_axi_bready |->
    ##[1:2] (s_axi_awready && s_axi_wready)) else $error("Write stuck");
endmodule
bind dcos_top dcos_monitor #(.DW(DW)) dcos_monitor_inst (
  .aclk, .aresetn, .s_axi_awready, .s_axi_wready, .s_axi_bvalid,
  .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
  .s_axi_rready, .s_axi_rdata, .in_valid, .out_valid, .out_q_valid,
  .out_q_data);

// ===== tb/dcos_source.sv
`timescale 1ns/1ps
// Upstream stages: random full-scale samples with random gaps
module dcos_source (
  // Clock and control
  input  wire logic        aclk,
  input  wire logic        run,
  // Samples toward the block
  output logic             in_valid,
  output logic [15:0]      in_a_data,
  output logic [15:0]      in_b_data
);
  logic [31:0] seed = 32'h0001161d;  // Fixed start keeps runs repeatable
  function automatic logic [31:0] xs(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  initial {in_valid, in_a_data, in_b_data} = 33'h0;
  // About one cycle in eight is idle, so strobes are not evenly spaced
  always @(posedge aclk) begin
    seed = xs(seed);
    in_valid  <= run && (seed[2:0] != 3'h0);
    in_a_data <= seed[31:16];
    in_b_data <= seed[23:8];
  end
endmodule

// ===== tb/dcos_top_tb.sv
`timescale 1ns/1ps
// Bench: bus tasks, a filter model, comparison at every output strobe once the 55-tap delay line is full
module dcos_top_tb;
  logic        aclk = 1'h0, aresetn = 1'h0, run = 1'h0;
  logic        awv = 1'h0, wv = 1'h0, bry = 1'h0, arv = 1'h0, rry = 1'h0;
  logic [11:0] awa = 12'h0, ara = 12'h0;
  logic [31:0] wd = 32'h0, rd;
  logic        awr, wr, bv, arr, rv, inv;
  logic [1:0]  br, rr, ov, oqv, the3;
  logic [15:0] ia, ib;
  logic [1:0][15:0] oi, oq, tw, po;
  logic [7:0]  dsel, cnt = 8'h01, mode [2] = '{8'h83, 8'h83};
  logic [7:0]  route [2] = '{8'h04, 8'h04};
  int          err_count = 0, cmp_count = 0, cyc = 0, n = 0;
  int          hi [2][55], hq [2][55], ph [2];
  logic [33:0] eq [2][$];  // {mature, q strobe, I, Q} per expected strobe
  localparam logic [9:0] IX [6] = '{10'h200, 10'h201, 10'h310, 10'h311,
                                    10'h330, 10'h331};
  localparam logic [7:0] EX [6] = '{8'h01, 8'h01, 8'h83, 8'h04, 8'h83, 8'h04};
  dcos_source dcos_source_inst (.aclk, .run, .in_valid(inv),
    .in_a_data(ia), .in_b_data(ib));
  dcos_top dcos_top_inst (.aclk, .aresetn, .s_axi_awaddr(awa),
    .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(wv), .s_axi_wready(wr),
    .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(bry),
    .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
    .s_axi_rdata(rd), .s_axi_rresp(rr), .s_axi_rvalid(rv),
    .s_axi_rready(rry), .in_valid(inv), .in_a_data(ia), .in_b_data(ib),
    .out_valid(ov), .out_q_valid(oqv), .out_i_data(oi), .out_q_data(oq),
    .oscillator_tuning_word(tw), .oscillator_phase_offset_word(po),
    .third_halfband_enable(the3), .chip_decimation_select(dsel));
  always #12.5 aclk = ~aclk;
  task automatic end_sim;
    $display("Comparisons %0d, mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      err_count++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  // Write one register; model count, both modes and channel 1 routing follow an accepted write
  task automatic wr_reg(input logic [9:0] x, input logic [7:0] d,
                        output logic [1:0] r);
    awa <= {x, 2'h0};
    wd <= {24'h0, d};
    {awv, wv, bry} <= 3'h7;
    do begin
      @(posedge aclk);
      if (awv && awr) awv <= 1'h0;
      if (wv && wr) wv <= 1'h0;
    end while (!bv);
    r = br;
    if (r == dcos_pkg::RESP_OKAY) begin
      if (x == dcos_pkg::IDX_CHANNEL_COUNT) cnt = d;
      if (x == dcos_pkg::IDX_CH0_MODE) mode[0] = d;
      if (x == dcos_pkg::IDX_CH1_MODE) mode[1] = d;
      if (x == dcos_pkg::IDX_CH1_ROUTING) route[1] = d;
    end
  endtask
  // Read with ready raised late, so the answer has to stand a cycle
  task automatic rd_reg(input logic [9:0] x, output logic [31:0] d,
                        output logic [1:0] r);
    ara <= {x, 2'h0};
    arv <= 1'h1;
    do @(posedge aclk); while (!arr);
    arv <= 1'h0;
    do @(posedge aclk); while (!rv);
    rry <= 1'h1;
    @(posedge aclk);
    d = rd;
    r = rr;
    rry <= 1'h0;
  endtask
  function automatic longint fir(input int c, input bit q);
    longint a;
    a = longint'(dcos_pkg::HB_CENTRE) * (q ? hq[c][27] : hi[c][27]);
    for (int k = 0; k < dcos_pkg::NPAIRS; k++)
      a += longint'(dcos_pkg::HB_COEF[k]) * (q ? hq[c][2*k] + hq[c][54-2*k]
                                               : hi[c][2*k] + hi[c][54-2*k]);
    return a;
  endfunction
  // Gain by shift, then clip to the output word
  function automatic logic [15:0] sc(input longint a, input logic g);
    a = a >>> (g ? 19 : 20);
    if (a > 32767) a = 32767;
    if (a < -32768) a = -32768;
    return a[15:0];
  endfunction
  // Model: shift routed samples, predict strobes, compare when they land
  always @(posedge aclk) begin
    longint f;
    logic [33:0] e;
    logic re, qv;
    if (!aresetn) begin
      n = 0;
      ph = '{0, 0};
      eq[0].delete();
      eq[1].delete();
    end else begin
      if (inv) n++;
      for (int c = 0; c < 2; c++) begin
        if (ov[c] && eq[c].size() == 0) chk(32'h1, 32'h0);
        else if (ov[c]) begin
          e = eq[c].pop_front();
          if (e[33]) chk({oi[c], oq[c]}, e[31:0]);
          if (e[33]) chk(oqv[c], e[32]);
        end
        if (inv) begin
          for (int k = 54; k > 0; k--) {hi[c][k], hq[c][k]} =
            {hi[c][k-1], hq[c][k-1]};
          hi[c][0] = route[c][0] ? $signed(ib) : $signed(ia);
          hq[c][0] = route[c][2] ? $signed(ib) : $signed(ia);
          re = mode[c][3];
          if (!re) ph[c] = 0;
          qv = !re && !cnt[5];
          f = fir(c, ph[c] % 2);
          if (ph[c] == 1 || ph[c] == 2) f = -f;
          if (((c == 0) ? cnt != 8'h0 : cnt[1]) && (re || n % 2 == 0)) begin
            eq[c].push_back({n >= 55, qv, sc(f, mode[c][6]),
                             qv ? sc(fir(c, 1), mode[c][6]) : 16'h0});
            if (re) ph[c] = (ph[c] + 1) % 4;
          end
        end
      end
    end
  end
  task automatic stream(input int k);
    run <= 1'h1;
    repeat (k) @(posedge aclk);
    run <= 1'h0;
    repeat (6) @(posedge aclk);
    chk(eq[0].size() + eq[1].size(), 0);
  endtask
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      end_sim;
    end
  end
  initial begin
    logic [31:0] d;
    logic [1:0] r;
    repeat (10) @(posedge aclk);
    aresetn <= 1'h1;
    repeat (2) @(posedge aclk);
    foreach (IX[k]) begin
      rd_reg(IX[k], d, r);
      chk(d, {24'h0, EX[k]});
    end
    rd_reg(10'h3ff, d, r);
    chk({d[29:0], r}, dcos_pkg::RESP_SLVERR);
    wr_reg(dcos_pkg::IDX_CH0_TUNING_A, 8'h5a, r);
    wr_reg(dcos_pkg::IDX_CH0_TUNING_B, 8'ha5, r);
    wr_reg(dcos_pkg::IDX_CH1_PHASE_B, 8'h3c, r);
    chk({tw[0], po[1]}, 32'ha55a3c00);
    wr_reg(dcos_pkg::IDX_CHIP_DECIMATION, 8'h02, r);
    chk(dsel, 8'h02);
    wr_reg(dcos_pkg::IDX_STATUS, 8'h00, r);
    chk(r, dcos_pkg::RESP_SLVERR);
    stream(400);
    wr_reg(dcos_pkg::IDX_CHANNEL_COUNT, 8'h02, r);
    wr_reg(dcos_pkg::IDX_CH1_MODE, 8'hc0, r);
    wr_reg(dcos_pkg::IDX_CH1_ROUTING, 8'h05, r);
    @(posedge aclk);
    chk(the3, 2'h2);
    stream(400);
    wr_reg(dcos_pkg::IDX_CHANNEL_COUNT, 8'h22, r);
    wr_reg(dcos_pkg::IDX_CH0_MODE, 8'h89, r);
    wr_reg(dcos_pkg::IDX_CH1_MODE, 8'hc9, r);
    stream(400);
    end_sim;
  end
endmodule
